// *** dlct_defs.vh ***
// constants for the dual legacy counter/timer block
`ifndef DLCT_DEFS_VH
`define DLCT_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DLCT_OFS_CTRL 8'h88
`define DLCT_OFS_MODE 8'h89
`define DLCT_OFS_A_LO 8'h8A
`define DLCT_OFS_B_LO 8'h8B
`define DLCT_OFS_A_HI 8'h8C
`define DLCT_OFS_B_HI 8'h8D

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DLCT_RST_CTRL 8'h00
`define DLCT_RST_MODE 8'h00
`define DLCT_RST_BYTE 8'h00

// ----------------------------------------------------------------
// control/status bit positions
// ----------------------------------------------------------------
`define DLCT_C_B_OVF 7
`define DLCT_C_B_RUN 6
`define DLCT_C_A_OVF 5
`define DLCT_C_A_RUN 4
`define DLCT_C_XB_FLAG 3
`define DLCT_C_XB_TYPE 2
`define DLCT_C_XA_FLAG 1
`define DLCT_C_XA_TYPE 0

// ----------------------------------------------------------------
// mode config bit positions
// ----------------------------------------------------------------
`define DLCT_M_B_GATE 7
`define DLCT_M_B_SRC 6
`define DLCT_M_B_MODE_HI 5
`define DLCT_M_B_MODE_LO 4
`define DLCT_M_A_GATE 3
`define DLCT_M_A_SRC 2
`define DLCT_M_A_MODE_HI 1
`define DLCT_M_A_MODE_LO 0

// ----------------------------------------------------------------
// modes and prescale codes
// ----------------------------------------------------------------
`define DLCT_MODE_13 2'h0
`define DLCT_MODE_16 2'h1
`define DLCT_MODE_RELOAD 2'h2
`define DLCT_MODE_SPLIT 2'h3
`define DLCT_PRE_DIV12 2'h0
`define DLCT_PRE_DIV4 2'h1
`define DLCT_PRE_DIV48 2'h2
`define DLCT_PRE_EXT8 2'h3

// ----------------------------------------------------------------
// divider terminal counts (divide by n ends at n-1)
// ----------------------------------------------------------------
`define DLCT_DIV12_END 6'h0B
`define DLCT_DIV4_END 6'h03
`define DLCT_DIV48_END 6'h2F
`define DLCT_EXT8_END 3'h7
`define DLCT_MAX13 13'h1FFF
`define DLCT_MAX16 16'hFFFF
`define DLCT_MAX8 8'hFF

`endif

// *** dlct_counter_timer.v ***
// dual legacy counter/timer: counters a and b, shared control and mode registers

`include "dlct_defs.vh"

// Function
// R1: counter mode counts event pin falling edges
// R2: event levels held two clocks minimum
// R3: source select bit picks pin or clock
// R4: clock select: system clock or prescaled clock
// R5: prescale bits pick shared divided clock
// R6: advance only with run and gate satisfied; counter b ignores both while a is split
// R7: counter b has own run, gate, polarity
// R8: run bit never clears or reloads count
// R9: mode 0 is 13-bit, low five bits
// R10: 13-bit wrap sets overflow flag, interrupt
// R11: mode 1 same but full 16 bits
// R12: mode 2 low byte reloads from high
// R13: split mode low byte uses a controls
// R14: split high byte timer, b run, b flag
// R15: a split: b timer only, no flag
// R16: two-bit field selects one of four modes
// R17: external flags level-following or edge-latched
// R18: overflow flag cleared by software or vector
// R19: synchronise pins, detect edges from samples
module dlct_counter_timer (
	// clock and reset
	input wire clk,
	input wire reset,
	// register port
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_wdata,
	output reg [7:0] sfr_rdata_q,
	// settings owned by other units
	input wire ctr_a_clock_select,
	input wire ctr_b_clock_select,
	input wire [1:0] prescale_select,
	input wire gate_a_polarity,
	input wire gate_b_polarity,
	input wire ctr_a_irq_enable,
	input wire ctr_b_irq_enable,
	// interrupt vector acknowledges
	input wire ctr_a_vector_ack,
	input wire ctr_b_vector_ack,
	input wire ext_a_vector_ack,
	input wire ext_b_vector_ack,
	// pins
	input wire event_pin_a,
	input wire event_pin_b,
	input wire gate_input_a,
	input wire gate_input_b,
	input wire ext_osc_clk,
	// requests and baud tick
	output reg ctr_a_irq_q,
	output reg ctr_b_irq_q,
	output reg ext_irq_a_q,
	output reg ext_irq_b_q,
	output reg ctr_b_baud_tick_q
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	wire [4:0] pin_raw;
	reg [4:0] sync1_q;
	reg [4:0] sync2_q;
	reg [4:0] prev_q;
	assign pin_raw = {ext_osc_clk, gate_input_b, gate_input_a, event_pin_b, event_pin_a};

	// two flops per pin, third flop only feeds edge detection
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
			always @(posedge clk) begin
				if (reset) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
					prev_q[gi] <= 1'b0;
				end else begin
					sync1_q[gi] <= pin_raw[gi]; // R19
					sync2_q[gi] <= sync1_q[gi];
					prev_q[gi] <= sync2_q[gi];
				end
			end
		end
	endgenerate

	// falling edges on event pins; inputs held two clocks are never missed
	wire ev_a_fall = prev_q[0] & ~sync2_q[0]; // R1 R2 R19
	wire ev_b_fall = prev_q[1] & ~sync2_q[1]; // R1 R19
	wire gate_a_act = (sync2_q[2] == gate_a_polarity);
	wire gate_b_act = (sync2_q[3] == gate_b_polarity); // R7
	wire gate_a_rise = gate_a_act & (prev_q[2] != gate_a_polarity);
	wire gate_b_rise = gate_b_act & (prev_q[3] != gate_b_polarity);
	wire osc_rise = ~prev_q[4] & sync2_q[4];

	// ------------------------------------------------------------
	// shared prescaler
	// ------------------------------------------------------------
	reg [5:0] div12_q;
	reg [5:0] div4_q;
	reg [5:0] div48_q;
	reg [2:0] ext8_q;
	reg pre_tick;

	// free-running dividers; the chosen one is sampled combinationally
	always @(posedge clk) begin
		if (reset) begin
			div12_q <= 6'h00;
			div4_q <= 6'h00;
			div48_q <= 6'h00;
			ext8_q <= 3'h0;
		end else begin
			div12_q <= (div12_q == `DLCT_DIV12_END) ? 6'h00 : div12_q + 6'h01;
			div4_q <= (div4_q == `DLCT_DIV4_END) ? 6'h00 : div4_q + 6'h01;
			div48_q <= (div48_q == `DLCT_DIV48_END) ? 6'h00 : div48_q + 6'h01;
			if (osc_rise)
				ext8_q <= ext8_q + 3'h1; // oscillator resynchronised first
		end
	end

	// prescale selection
	always @* begin
		case (prescale_select) // R5
			`DLCT_PRE_DIV12: pre_tick = (div12_q == `DLCT_DIV12_END);
			`DLCT_PRE_DIV4: pre_tick = (div4_q == `DLCT_DIV4_END);
			`DLCT_PRE_DIV48: pre_tick = (div48_q == `DLCT_DIV48_END);
			default: pre_tick = osc_rise & (ext8_q == `DLCT_EXT8_END);
		endcase
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	reg [7:0] ctrl_q;
	reg [7:0] mode_q;
	reg [7:0] a_lo_q, a_hi_q, b_lo_q, b_hi_q;
	reg [7:0] a_lo_d, a_hi_d, b_lo_d, b_hi_d;
	reg a_ovf, ah_ovf, b_ovf;
	reg [12:0] sum13;
	reg [15:0] sum16;

	wire [1:0] mode_a = mode_q[`DLCT_M_A_MODE_HI:`DLCT_M_A_MODE_LO]; // R16
	wire [1:0] mode_b = mode_q[`DLCT_M_B_MODE_HI:`DLCT_M_B_MODE_LO]; // R16
	wire a_split = (mode_a == `DLCT_MODE_SPLIT);
	wire run_a_bit = ctrl_q[`DLCT_C_A_RUN];
	wire run_b_bit = ctrl_q[`DLCT_C_B_RUN];

	// timer clocks from the clock-select bits
	wire tmr_a_tick = ctr_a_clock_select | pre_tick; // R4
	wire tmr_b_tick = ctr_b_clock_select | pre_tick; // R4

	// per-counter tick and enable
	wire tick_a = mode_q[`DLCT_M_A_SRC] ? ev_a_fall : tmr_a_tick; // R3
	wire en_a = run_a_bit & (~mode_q[`DLCT_M_A_GATE] | gate_a_act); // R6
	// counter b: no pin clocking and free run while a is split
	wire tick_b = (~a_split & mode_q[`DLCT_M_B_SRC]) ? ev_b_fall : tmr_b_tick; // R15
	wire en_b = a_split ? 1'b1 : (run_b_bit & (~mode_q[`DLCT_M_B_GATE] | gate_b_act)); // R7 R15
	wire wr_ctrl = sfr_wr & (sfr_addr == `DLCT_OFS_CTRL);

	// counter a next value
	always @* begin
		a_lo_d = a_lo_q;
		a_hi_d = a_hi_q;
		a_ovf = 1'b0;
		ah_ovf = 1'b0;
		sum13 = {a_hi_q, a_lo_q[4:0]} + 13'h0001;
		sum16 = {a_hi_q, a_lo_q} + 16'h0001;
		if (en_a & tick_a) begin // R8
			case (mode_a)
				`DLCT_MODE_13: begin
					// upper three low-byte bits are left untouched
					a_hi_d = sum13[12:5]; // R9
					a_lo_d = {a_lo_q[7:5], sum13[4:0]};
					a_ovf = ({a_hi_q, a_lo_q[4:0]} == `DLCT_MAX13); // R10
				end
				`DLCT_MODE_16: begin
					a_hi_d = sum16[15:8]; // R11
					a_lo_d = sum16[7:0];
					a_ovf = ({a_hi_q, a_lo_q} == `DLCT_MAX16); // R11
				end
				`DLCT_MODE_RELOAD: begin
					a_ovf = (a_lo_q == `DLCT_MAX8);
					a_lo_d = a_ovf ? a_hi_q : a_lo_q + 8'h01; // R12
				end
				default: begin
					a_lo_d = a_lo_q + 8'h01; // R13
					a_ovf = (a_lo_q == `DLCT_MAX8); // R13
				end
			endcase
		end
		// split high byte is a timer run by counter b's run bit
		if (a_split & run_b_bit & tmr_a_tick) begin
			a_hi_d = a_hi_q + 8'h01; // R14
			ah_ovf = (a_hi_q == `DLCT_MAX8); // R14
		end
		// a software write beats any count in the same cycle
		if (sfr_wr & (sfr_addr == `DLCT_OFS_A_LO))
			a_lo_d = sfr_wdata;
		if (sfr_wr & (sfr_addr == `DLCT_OFS_A_HI))
			a_hi_d = sfr_wdata;
	end

	// counter b next value
	always @* begin
		b_lo_d = b_lo_q;
		b_hi_d = b_hi_q;
		b_ovf = 1'b0;
		if (en_b & tick_b) begin
			case (mode_b)
				`DLCT_MODE_13: begin
					{b_hi_d, b_lo_d[4:0]} = {b_hi_q, b_lo_q[4:0]} + 13'h0001; // R9
					b_ovf = ({b_hi_q, b_lo_q[4:0]} == `DLCT_MAX13); // R10
				end
				`DLCT_MODE_16: begin
					{b_hi_d, b_lo_d} = {b_hi_q, b_lo_q} + 16'h0001; // R11
					b_ovf = ({b_hi_q, b_lo_q} == `DLCT_MAX16);
				end
				`DLCT_MODE_RELOAD: begin
					b_ovf = (b_lo_q == `DLCT_MAX8);
					b_lo_d = b_ovf ? b_hi_q : b_lo_q + 8'h01; // R12
				end
				default: begin
					b_ovf = 1'b0; // R15 R16
				end
			endcase
		end
		if (sfr_wr & (sfr_addr == `DLCT_OFS_B_LO))
			b_lo_d = sfr_wdata;
		if (sfr_wr & (sfr_addr == `DLCT_OFS_B_HI))
			b_hi_d = sfr_wdata;
	end

	// count registers and mode register
	always @(posedge clk) begin
		if (reset) begin
			a_lo_q <= `DLCT_RST_BYTE;
			a_hi_q <= `DLCT_RST_BYTE;
			b_lo_q <= `DLCT_RST_BYTE;
			b_hi_q <= `DLCT_RST_BYTE;
			mode_q <= `DLCT_RST_MODE;
		end else begin
			a_lo_q <= a_lo_d;
			a_hi_q <= a_hi_d;
			b_lo_q <= b_lo_d;
			b_hi_q <= b_hi_d;
			if (sfr_wr & (sfr_addr == `DLCT_OFS_MODE))
				mode_q <= sfr_wdata;
		end
	end

	// ------------------------------------------------------------
	// control/status flags: hardware set beats any clear
	// ------------------------------------------------------------
	wire set_a_ovf = a_ovf;
	wire set_b_ovf = ah_ovf | (b_ovf & ~a_split); // R14 R15
	wire xa_edge = ctrl_q[`DLCT_C_XA_TYPE];
	wire xb_edge = ctrl_q[`DLCT_C_XB_TYPE];

	always @(posedge clk) begin
		if (reset) begin
			ctrl_q <= `DLCT_RST_CTRL;
		end else begin
			// run and type bits are plain software state
			if (wr_ctrl) begin
				ctrl_q[`DLCT_C_B_RUN] <= sfr_wdata[`DLCT_C_B_RUN];
				ctrl_q[`DLCT_C_A_RUN] <= sfr_wdata[`DLCT_C_A_RUN];
				ctrl_q[`DLCT_C_XB_TYPE] <= sfr_wdata[`DLCT_C_XB_TYPE];
				ctrl_q[`DLCT_C_XA_TYPE] <= sfr_wdata[`DLCT_C_XA_TYPE];
			end
			// overflow flags
			if (set_a_ovf)
				ctrl_q[`DLCT_C_A_OVF] <= 1'b1; // R10
			else if (ctr_a_vector_ack)
				ctrl_q[`DLCT_C_A_OVF] <= 1'b0; // R18
			else if (wr_ctrl)
				ctrl_q[`DLCT_C_A_OVF] <= sfr_wdata[`DLCT_C_A_OVF]; // R18
			if (set_b_ovf)
				ctrl_q[`DLCT_C_B_OVF] <= 1'b1; // R14
			else if (ctr_b_vector_ack)
				ctrl_q[`DLCT_C_B_OVF] <= 1'b0; // R18
			else if (wr_ctrl)
				ctrl_q[`DLCT_C_B_OVF] <= sfr_wdata[`DLCT_C_B_OVF];
			// external flags: level mode tracks the active level
			if (~xa_edge)
				ctrl_q[`DLCT_C_XA_FLAG] <= gate_a_act; // R17
			else if (gate_a_rise)
				ctrl_q[`DLCT_C_XA_FLAG] <= 1'b1; // R17
			else if (ext_a_vector_ack)
				ctrl_q[`DLCT_C_XA_FLAG] <= 1'b0; // R17
			else if (wr_ctrl)
				ctrl_q[`DLCT_C_XA_FLAG] <= sfr_wdata[`DLCT_C_XA_FLAG];
			if (~xb_edge)
				ctrl_q[`DLCT_C_XB_FLAG] <= gate_b_act; // R17
			else if (gate_b_rise)
				ctrl_q[`DLCT_C_XB_FLAG] <= 1'b1; // R17
			else if (ext_b_vector_ack)
				ctrl_q[`DLCT_C_XB_FLAG] <= 1'b0; // R17
			else if (wr_ctrl)
				ctrl_q[`DLCT_C_XB_FLAG] <= sfr_wdata[`DLCT_C_XB_FLAG];
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// requests follow flags one cycle late; baud tick keeps running in split mode
	always @(posedge clk) begin
		if (reset) begin
			ctr_a_irq_q <= 1'b0;
			ctr_b_irq_q <= 1'b0;
			ext_irq_a_q <= 1'b0;
			ext_irq_b_q <= 1'b0;
			ctr_b_baud_tick_q <= 1'b0;
		end else begin
			ctr_a_irq_q <= ctrl_q[`DLCT_C_A_OVF] & ctr_a_irq_enable; // R10
			ctr_b_irq_q <= ctrl_q[`DLCT_C_B_OVF] & ctr_b_irq_enable; // R14
			ext_irq_a_q <= ctrl_q[`DLCT_C_XA_FLAG];
			ext_irq_b_q <= ctrl_q[`DLCT_C_XB_FLAG];
			ctr_b_baud_tick_q <= b_ovf; // R15
		end
	end

	// registered read data; unmapped offsets read zero
	always @(posedge clk) begin
		if (reset) begin
			sfr_rdata_q <= 8'h00;
		end else if (sfr_rd) begin
			case (sfr_addr)
				`DLCT_OFS_CTRL: sfr_rdata_q <= ctrl_q;
				`DLCT_OFS_MODE: sfr_rdata_q <= mode_q;
				`DLCT_OFS_A_LO: sfr_rdata_q <= a_lo_q;
				`DLCT_OFS_A_HI: sfr_rdata_q <= a_hi_q;
				`DLCT_OFS_B_LO: sfr_rdata_q <= b_lo_q;
				`DLCT_OFS_B_HI: sfr_rdata_q <= b_hi_q;
				default: sfr_rdata_q <= 8'h00;
			endcase
		end
	end

endmodule // dlct_counter_timer

// *** dlct_checker_asserts.sv ***
// port-level assertions for the dual legacy counter/timer
`include "dlct_defs.vh"
module dlct_checker (
	// clock and reset
	input wire clk,
	input wire reset,
	// register port
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_wdata,
	input wire [7:0] sfr_rdata_q,
	// enables and acknowledges
	input wire ctr_a_irq_enable,
	input wire ctr_b_irq_enable,
	input wire ctr_a_vector_ack,
	input wire ctr_b_vector_ack,
	// requests
	input wire ctr_a_irq_q,
	input wire ctr_b_irq_q
);
	timeunit 1ns;
	timeprecision 1ns;
	// a control write may legally clear a flag, so sticky checks skip it
	wire ctrl_wr = sfr_wr && (sfr_addr == `DLCT_OFS_CTRL);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	a_irq_a_masked: assert property (!ctr_a_irq_enable |=> !ctr_a_irq_q)
		else $error("counter a request while masked");
	a_irq_b_masked: assert property (!ctr_b_irq_enable |=> !ctr_b_irq_q)
		else $error("counter b request while masked");
	a_flag_a_sticky: assert property ((!ctr_a_vector_ack && !ctrl_wr) ##1
		(ctr_a_irq_q && ctr_a_irq_enable) |=> ctr_a_irq_q) else $error("a flag dropped");
	a_flag_b_sticky: assert property ((!ctr_b_vector_ack && !ctrl_wr) ##1
		(ctr_b_irq_q && ctr_b_irq_enable) |=> ctr_b_irq_q) else $error("b flag dropped");
	a_mode_readback: assert property (sfr_wr && sfr_addr == `DLCT_OFS_MODE ##2
		sfr_rd && sfr_addr == `DLCT_OFS_MODE |=> sfr_rdata_q == $past(sfr_wdata, 3))
		else $error("mode readback differs");
	a_ctrl_readback: assert property (ctrl_wr ##2
		sfr_rd && sfr_addr == `DLCT_OFS_CTRL |=> (sfr_rdata_q & 8'h55) == ($past(sfr_wdata, 3) & 8'h55))
		else $error("control readback differs");
	a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata_q))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (sfr_rd && (sfr_addr < 8'h88 || sfr_addr > 8'h8D)
		|=> sfr_rdata_q == 8'h00) else $error("unmapped read not zero");
endmodule // dlct_checker

bind dlct_counter_timer dlct_checker chk_u (.clk, .reset, .sfr_addr, .sfr_wr, .sfr_rd,
	.sfr_wdata, .sfr_rdata_q, .ctr_a_irq_enable, .ctr_b_irq_enable, .ctr_a_vector_ack,
	.ctr_b_vector_ack, .ctr_a_irq_q, .ctr_b_irq_q);

// *** dlct_pin_model.sv ***
// pin-side stand-in: event pulse trains and gate levels
module dlct_pin_model (
	// clock
	input wire clk,
	// commands from the bench
	input wire go,
	input wire which,
	input wire [7:0] count,
	input wire gate_a_level,
	input wire gate_b_level,
	// pins
	output reg event_pin_a,
	output reg event_pin_b,
	output wire gate_input_a,
	output wire gate_input_b,
	output reg busy
);
	timeunit 1ns;
	timeprecision 1ns;
	integer i;
	// gate pins are plain levels chosen by the bench
	assign gate_input_a = gate_a_level;
	assign gate_input_b = gate_b_level;
	// every level held two clocks: the fastest pacing the device must accept
	initial begin
		event_pin_a = 1'b1;
		event_pin_b = 1'b1;
		busy = 1'b0;
		forever begin
			@(posedge go);
			busy = 1'b1;
			for (i = 0; i < count; i = i + 1) begin
				@(negedge clk);
				if (which) event_pin_b = 1'b0; else event_pin_a = 1'b0;
				repeat (2) @(negedge clk);
				event_pin_a = 1'b1;
				event_pin_b = 1'b1;
				@(negedge clk);
			end
			busy = 1'b0;
		end
	end
endmodule // dlct_pin_model

// *** tb_top.sv ***
// self-checking bench for the dual legacy counter/timer
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, reset = 1, sfr_wr = 0, sfr_rd = 0, go = 0, which = 0;
	logic [7:0] sfr_addr = 0, sfr_wdata = 0, count = 0;
	logic ctr_a_clock_select = 1, ctr_b_clock_select = 1, gate_a_polarity = 1, gate_b_polarity = 1;
	logic ctr_a_irq_enable = 1, ctr_b_irq_enable = 1, ctr_a_vector_ack = 0, ctr_b_vector_ack = 0;
	logic [1:0] prescale_select = 0;
	logic gla = 0, glb = 0;
	logic ext_a_vector_ack = 0, ext_b_vector_ack = 0, ext_osc_clk = 0;
	wire event_pin_a, event_pin_b, gate_input_a, gate_input_b, busy;
	wire ctr_a_irq_q, ctr_b_irq_q, ext_irq_a_q, ext_irq_b_q, ctr_b_baud_tick_q;
	wire [7:0] sfr_rdata_q;
	integer fail_count = 0, check_count = 0;
	dlct_counter_timer dut_u (.clk, .reset, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
		.sfr_rdata_q, .ctr_a_clock_select, .ctr_b_clock_select, .prescale_select,
		.gate_a_polarity, .gate_b_polarity, .ctr_a_irq_enable, .ctr_b_irq_enable,
		.ctr_a_vector_ack, .ctr_b_vector_ack, .ext_a_vector_ack, .ext_b_vector_ack,
		.event_pin_a, .event_pin_b, .gate_input_a, .gate_input_b, .ext_osc_clk,
		.ctr_a_irq_q, .ctr_b_irq_q, .ext_irq_a_q, .ext_irq_b_q, .ctr_b_baud_tick_q);
	dlct_pin_model pin_u (.clk, .go, .which, .count, .gate_a_level(gla), .gate_b_level(glb),
		.event_pin_a, .event_pin_b, .gate_input_a, .gate_input_b, .busy);
	always #5 clk = ~clk;
	// slow oscillator stand-in: eight clocks per period, well under clk/4
	always begin
		repeat (4) @(negedge clk);
		ext_osc_clk = ~ext_osc_clk;
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one register access; strobes rise and fall on falling edges
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_wr = w;
		sfr_rd = !w;
		sfr_addr = a;
		sfr_wdata = d;
		@(negedge clk);
		sfr_wr = 0;
		sfr_rd = 0;
	endtask
	task automatic rd(input logic [7:0] a, m, exp, input string nm);
		acc(0, a, 8'h00);
		chk(nm, exp, sfr_rdata_q & m);
	endtask
	task automatic t_regs;
		for (logic [7:0] a = 8'h88; a <= 8'h8D; a++) rd(a, 8'hFF, 8'h00, "reset value");
		acc(1, 8'h89, 8'hA5);
		rd(8'h89, 8'hFF, 8'hA5, "mode readback");
		acc(1, 8'h88, 8'h55);
		rd(8'h88, 8'h55, 8'h55, "control readback");
		acc(1, 8'h90, 8'hFF);
		rd(8'h90, 8'hFF, 8'h00, "unmapped read");
		$display("register test done");
	endtask
	// preload, send pin events, then compare count, flag and request
	task automatic cnt_case(input logic b, input logic [1:0] md, input logic [7:0] hi, lo,
		input logic [7:0] n, lm, ehi, elo, input logic fl);
		logic [7:0] fb;
		int k;
		fb = b ? 8'h80 : 8'h20;
		acc(1, 8'h88, 8'h00);
		acc(1, 8'h89, {4'h0, 2'b01, md} << (b * 4));
		acc(1, 8'h8A + b, lo);
		acc(1, 8'h8C + b, hi);
		acc(1, 8'h88, fb >> 1);
		which = b;
		count = n;
		go = 1;
		@(negedge clk);
		go = 0;
		for (k = 0; k < 100 && busy; k++) @(negedge clk);
		if (busy) begin
			fail_count++;
			complete_run();
		end
		repeat (6) @(negedge clk);
		rd(8'h8A + b, lm, elo, "low byte");
		rd(8'h8C + b, 8'hFF, ehi, "high byte");
		rd(8'h88, fb, fl ? fb : 8'h00, "overflow flag");
		chk("request", {7'h0, fl}, {7'h0, b ? ctr_b_irq_q : ctr_a_irq_q});
		if (fl) begin
			if (b) ctr_b_irq_enable = 0; else ctr_a_irq_enable = 0;
			repeat (2) @(negedge clk);
			chk("masked request", 8'h00, {7'h0, b ? ctr_b_irq_q : ctr_a_irq_q});
			ctr_a_irq_enable = 1;
			ctr_b_irq_enable = 1;
			if (b) ctr_b_vector_ack = 1; else ctr_a_vector_ack = 1;
			@(negedge clk);
			ctr_a_vector_ack = 0;
			ctr_b_vector_ack = 0;
			@(negedge clk);
			chk("request after ack", 8'h00, {7'h0, b ? ctr_b_irq_q : ctr_a_irq_q});
			rd(8'h88, fb, 8'h00, "flag after ack");
		end
		$display("count case done");
	endtask
	task automatic t_gate;
		acc(1, 8'h88, 8'h00);
		acc(1, 8'h89, 8'h09);
		acc(1, 8'h8A, 8'h00);
		acc(1, 8'h8C, 8'h00);
		acc(1, 8'h88, 8'h10);
		repeat (10) @(negedge clk);
		rd(8'h8A, 8'hFF, 8'h00, "gated hold");
		gla = 1;
		repeat (10) @(negedge clk);
		gla = 0;
		repeat (5) @(negedge clk);
		rd(8'h8A, 8'hFF, 8'h0A, "gated count");
		$display("gate test done");
	endtask
	// external flags: level follows the gate pin, edge latches until the vector ack
	task automatic t_ext;
		acc(1, 8'h88, 8'h00);
		gate_b_polarity = 0;
		gla = 1;
		repeat (5) @(negedge clk);
		chk("level flag a", 8'h01, {7'h0, ext_irq_a_q});
		chk("low-active flag b", 8'h01, {7'h0, ext_irq_b_q});
		gla = 0;
		gate_b_polarity = 1;
		repeat (5) @(negedge clk);
		chk("level flag a idle", 8'h00, {7'h0, ext_irq_a_q});
		chk("level flag b idle", 8'h00, {7'h0, ext_irq_b_q});
		acc(1, 8'h88, 8'h01);
		gla = 1;
		repeat (5) @(negedge clk);
		gla = 0;
		repeat (5) @(negedge clk);
		chk("edge flag held", 8'h01, {7'h0, ext_irq_a_q});
		ext_a_vector_ack = 1;
		@(negedge clk);
		ext_a_vector_ack = 0;
		@(negedge clk);
		rd(8'h88, 8'h02, 8'h00, "edge flag after ack");
		chk("edge request after ack", 8'h00, {7'h0, ext_irq_a_q});
		$display("external flag test done");
	endtask
	// timer off the shared prescaler: the run window spans exactly 192 clock edges
	task automatic t_prescale;
		logic [7:0] pe;
		ctr_a_clock_select = 0;
		for (int p = 0; p < 4; p++) begin
			prescale_select = p[1:0];
			acc(1, 8'h88, 8'h00);
			acc(1, 8'h89, 8'h01);
			acc(1, 8'h8A, 8'h20);
			acc(1, 8'h8C, 8'h00);
			acc(1, 8'h88, 8'h10);
			repeat (190) @(negedge clk);
			acc(1, 8'h88, 8'h00);
			// preload plus 192/12, 192/4, 192/48 and 192/64 (oscillator over 8)
			pe = (p == 0) ? 8'h30 : (p == 1) ? 8'h50 : (p == 2) ? 8'h24 : 8'h23;
			rd(8'h8A, 8'hFF, pe, "prescaled count");
		end
		ctr_a_clock_select = 1;
		prescale_select = 0;
		$display("prescale test done");
	endtask
	// split mode: a high byte is a timer run by the b run bit
	task automatic t_split;
		int k;
		acc(1, 8'h88, 8'h00);
		acc(1, 8'h89, 8'h23);
		acc(1, 8'h8A, 8'h00);
		acc(1, 8'h8C, 8'hFE);
		// counter b reloads free-running while a is split; it ticks but never flags
		acc(1, 8'h8D, 8'hFE);
		acc(1, 8'h8B, 8'hFF);
		for (k = 0; k < 20 && ctr_b_baud_tick_q !== 1'b1; k++) @(negedge clk);
		chk("baud tick", 8'h01, {7'h0, ctr_b_baud_tick_q});
		rd(8'h88, 8'h80, 8'h00, "split b no flag");
		acc(1, 8'h88, 8'h40);
		for (k = 0; k < 20 && ctr_b_irq_q !== 1'b1; k++) @(negedge clk);
		chk("split request", 8'h01, {7'h0, ctr_b_irq_q});
		ctr_b_irq_enable = 0;
		repeat (2) @(negedge clk);
		chk("split masked", 8'h00, {7'h0, ctr_b_irq_q});
		ctr_b_irq_enable = 1;
		rd(8'h88, 8'hA0, 8'h80, "split flags");
		rd(8'h8A, 8'hFF, 8'h00, "split low idle");
		$display("split test done");
	endtask
	initial begin
		repeat (5) @(negedge clk);
		reset = 0;
		t_regs();
		cnt_case(0, 2'h0, 8'hFF, 8'hFE, 2, 8'h1F, 8'h00, 8'h00, 1);
		cnt_case(0, 2'h1, 8'hFF, 8'hFE, 3, 8'hFF, 8'h00, 8'h01, 1);
		cnt_case(0, 2'h2, 8'h10, 8'hFE, 2, 8'hFF, 8'h10, 8'h10, 1);
		cnt_case(1, 2'h2, 8'h80, 8'hFF, 1, 8'hFF, 8'h80, 8'h80, 1);
		cnt_case(1, 2'h1, 8'h12, 8'h34, 1, 8'hFF, 8'h12, 8'h35, 0);
		t_gate();
		t_ext();
		t_prescale();
		t_split();
		complete_run();
	end
endmodule // tb_top
